// ==== src/swl_params.svh ====
// constants for the single-wire slave command port
//------------------------------------------------------------
// What this block does
// - every transaction opens with reset then presence
// - after reset rise, wait then pull low
// - read-address opcode 33h or 39h by select
// - match address; mismatch ignores until reset
// - skip address goes straight to function command
// - search: bit, complement, master bit, drop out
// - read data LSb first, auto-increment per byte
// - reads past FFh return ones until reset
// - reset at any bit boundary aborts transfer
// - write data LSb first; beyond FFh discarded
// - discard protected writes and incomplete bytes
// - nonvolatile writes land in shadow RAM
// - copy shadow block to nonvolatile unless locked
// - copy busy flag; nonvolatile writes rejected meanwhile
// - copy lasts copy_time from last address bit
// - recall loads nonvolatile block into shadow RAM
// - lock block only when lock_enable set
// - slots 60 to 120us, 1us recovery
// - write slot sampled between 15 and 60us
// - read slot: device drives, master samples 15us
// - device releases line before read slot ends
// - low over 120us is a reset pulse
// - lock clears lock_enable unless lock_enable_set is high that cycle
//------------------------------------------------------------
`ifndef SWL_PARAMS_SVH
`define SWL_PARAMS_SVH

`define SWL_CLK_MHZ        50
// times in microseconds
`define SWL_RESET_LOW_US   120
`define SWL_PRES_WAIT_US   30
`define SWL_PRES_LOW_US    120
`define SWL_SAMPLE_US      30
`define SWL_COPY_TIME_US   2000
// cycle counts
`define SWL_RST_CYC   (`SWL_RESET_LOW_US * `SWL_CLK_MHZ)
`define SWL_PWAIT_CYC (`SWL_PRES_WAIT_US * `SWL_CLK_MHZ)
`define SWL_PLOW_CYC  (`SWL_PRES_LOW_US * `SWL_CLK_MHZ)
`define SWL_SAMPLE_CYC (`SWL_SAMPLE_US * `SWL_CLK_MHZ)
`define SWL_COPY_CYC  (`SWL_COPY_TIME_US * `SWL_CLK_MHZ)
// opcodes
`define SWL_OP_RNA0    8'h33
`define SWL_OP_RNA1    8'h39
`define SWL_OP_MATCH   8'h55
`define SWL_OP_SKIP    8'hCC
`define SWL_OP_SEARCH  8'hF0
`define SWL_OP_READ    8'h69
`define SWL_OP_WRITE   8'h6C
`define SWL_OP_COPY    8'h48
`define SWL_OP_RECALL  8'hB8
`define SWL_OP_LOCK    8'h6A
// address map
`define SWL_NV_TOP     3'h1
`define SWL_ADDR_LAST  8'hFF
`define SWL_FIFO_DEPTH 8

`endif

// ==== src/swl_pkg.sv ====
// types for the single-wire slave command port
package swl_pkg;
  typedef enum logic [1:0] {L_IDLE, L_RST, L_PWAIT, L_PLOW} swl_link_t;
  typedef enum logic [3:0] {
    P_WAIT, P_ROMCMD, P_READROM, P_MATCH, P_SEARCH,
    P_FUNC, P_ADDR, P_RDATA, P_WDATA
  } swl_proto_t;
endpackage : swl_pkg

// ==== src/swl_fifo.sv ====
// small synchronous fifo for the write stream
`timescale 1ns/1ns
`default_nettype none
module swl_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_ff [D];
  logic [AW:0]  wp_ff;
  logic [AW:0]  rp_ff;
  logic         push;
  logic         pop;

  assign in_ready  = (wp_ff - rp_ff) != (AW+1)'(D);
  assign out_valid = wp_ff != rp_ff;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_ff[rp_ff[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wp_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end
endmodule : swl_fifo
`default_nettype wire

// ==== src/swl_slave.sv ====
// single-wire slave: line timing, address and memory commands
`timescale 1ns/1ns
`default_nettype none
`include "swl_params.svh"
module swl_slave #(
  parameter int RST_CYC    = `SWL_RST_CYC,
  parameter int PWAIT_CYC  = `SWL_PWAIT_CYC,
  parameter int PLOW_CYC   = `SWL_PLOW_CYC,
  parameter int SMP_CYC    = `SWL_SAMPLE_CYC,
  parameter int COPY_CYC   = `SWL_COPY_CYC,
  parameter int FIFO_DEPTH = `SWL_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // bus line
  input  wire logic        dq_in,
  output logic             dq_out,
  output logic             dq_oe,
  // identity and configuration
  input  wire logic [63:0] net_address,
  input  wire logic        net_address_opcode_select,
  input  wire logic        lock_enable_set,
  output logic             lock_enable,
  input  wire logic [1:0]  block_locked,
  output logic             eeprom_copy_busy,
  output swl_pkg::swl_link_t link_state,
  // memory read and map
  output logic [7:0]       mem_addr,
  output logic             mem_rd_req,
  input  wire logic [7:0]  mem_rd_data,
  input  wire logic        mem_addr_writable,
  // shadow write stream
  output logic             mem_wr_valid,
  input  wire logic        mem_wr_ready,
  output logic [7:0]       mem_wr_addr,
  output logic [7:0]       mem_wr_data,
  // nonvolatile control
  output logic             nv_copy_req,
  output logic             nv_recall_req,
  output logic             nv_lock_req,
  output logic             nv_block
);
  import swl_pkg::*;

  localparam int LMX = RST_CYC > PLOW_CYC ? RST_CYC : PLOW_CYC;
  localparam int LW = $clog2((LMX > PWAIT_CYC ? LMX : PWAIT_CYC) + 1);
  localparam int SW = $clog2(SMP_CYC + 1);
  localparam int CW = $clog2(COPY_CYC + 1);
  localparam logic [LW-1:0] RST_N  = LW'(RST_CYC);
  localparam logic [LW-1:0] PW_N   = LW'(PWAIT_CYC);
  localparam logic [LW-1:0] PL_N   = LW'(PLOW_CYC);
  localparam logic [SW-1:0] SMP_N  = SW'(SMP_CYC);
  localparam logic [CW-1:0] COPY_N = CW'(COPY_CYC);

  //------------------------------------------------------------
  // line synchroniser and edges
  //------------------------------------------------------------
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic fall;
  logic rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else begin
      s1_ff <= dq_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign fall = s3_ff & ~s2_ff;
  assign rise = ~s3_ff & s2_ff;

  //------------------------------------------------------------
  // reset pulse detection and presence
  //------------------------------------------------------------
  swl_link_t     link_ff;
  logic [LW-1:0] low_cnt_ff;
  logic [LW-1:0] tmr_ff;
  logic          rst_hit;
  logic          pres_end;

  // own presence pulse must not look like a reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_ff <= '0;
    end else if (s2_ff || link_ff == L_PLOW) begin
      low_cnt_ff <= '0;
    end else if (low_cnt_ff != RST_N) begin
      low_cnt_ff <= low_cnt_ff + 1'b1;
    end
  end

  assign rst_hit  = (low_cnt_ff == RST_N) && (link_ff != L_RST);
  assign pres_end = (link_ff == L_PLOW) && (tmr_ff == PL_N - 1'b1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_ff <= L_IDLE;
      tmr_ff  <= '0;
    end else if (rst_hit) begin
      link_ff <= L_RST;
    end else begin
      case (link_ff)
        L_IDLE: begin
          tmr_ff <= '0;
        end
        L_RST: begin
          if (rise) begin
            link_ff <= L_PWAIT;
            tmr_ff  <= '0;
          end
        end
        L_PWAIT: begin
          tmr_ff <= tmr_ff + 1'b1;
          if (tmr_ff == PW_N - 1'b1) begin
            link_ff <= L_PLOW;
            tmr_ff  <= '0;
          end
        end
        L_PLOW: begin
          tmr_ff <= tmr_ff + 1'b1;
          if (pres_end) begin
            link_ff <= L_IDLE;
          end
        end
        default: begin
          link_ff <= L_IDLE;
        end
      endcase
    end
  end

  assign link_state = link_ff;

  //------------------------------------------------------------
  // time slots
  //------------------------------------------------------------
  logic          slot_ff;
  logic [SW-1:0] slot_cnt_ff;
  logic          bit_done;
  logic          rx;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_ff     <= 1'b0;
      slot_cnt_ff <= '0;
    end else if (rst_hit) begin
      slot_ff <= 1'b0;
    end else if (!slot_ff) begin
      if (fall && link_ff == L_IDLE) begin
        slot_ff     <= 1'b1;
        slot_cnt_ff <= '0;
      end
    end else begin
      slot_cnt_ff <= slot_cnt_ff + 1'b1;
      if (bit_done) begin
        slot_ff <= 1'b0;
      end
    end
  end

  // sample 30us into the slot
  assign bit_done = slot_ff && (slot_cnt_ff == SMP_N - 1'b1);
  assign rx       = s2_ff;

  //------------------------------------------------------------
  // command sequencer
  //------------------------------------------------------------
  swl_proto_t proto_ff;
  logic [5:0] bcnt_ff;
  logic [1:0] sub_ff;
  logic       miss_ff;
  logic [7:0] fcmd_ff;
  logic [7:0] addr_ff;
  logic [7:0] sh_ff;
  logic       past_ff;
  logic       rd_req_ff;
  logic       ld_ff;
  logic [7:0] byte_in;
  logic       last8;
  logic       amiss;
  logic [7:0] rna_op;

  assign byte_in = {rx, sh_ff[7:1]};
  assign last8   = bcnt_ff == 6'h07;
  assign amiss   = rx != net_address[bcnt_ff];
  assign rna_op  = net_address_opcode_select ? `SWL_OP_RNA1 : `SWL_OP_RNA0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      proto_ff  <= P_WAIT;
      bcnt_ff   <= '0;
      sub_ff    <= '0;
      miss_ff   <= 1'b0;
      fcmd_ff   <= '0;
      addr_ff   <= '0;
      sh_ff     <= '0;
      past_ff   <= 1'b0;
      rd_req_ff <= 1'b0;
      ld_ff     <= 1'b0;
    end else if (rst_hit) begin
      proto_ff  <= P_WAIT;
      rd_req_ff <= 1'b0;
      ld_ff     <= 1'b0;
    end else if (pres_end) begin
      proto_ff <= P_ROMCMD;
      bcnt_ff  <= '0;
      sub_ff   <= '0;
      miss_ff  <= 1'b0;
    end else begin
      rd_req_ff <= 1'b0;
      ld_ff     <= rd_req_ff;
      if (ld_ff) begin
        sh_ff <= mem_rd_data;
      end
      if (bit_done) begin
        case (proto_ff)
          P_ROMCMD: begin
            sh_ff   <= byte_in;
            bcnt_ff <= last8 ? 6'h00 : bcnt_ff + 6'h01;
            if (last8) begin
              if (byte_in == rna_op) begin
                proto_ff <= P_READROM;
              end else if (byte_in == `SWL_OP_MATCH) begin
                proto_ff <= P_MATCH;
              end else if (byte_in == `SWL_OP_SKIP) begin
                proto_ff <= P_FUNC;
              end else if (byte_in == `SWL_OP_SEARCH) begin
                proto_ff <= P_SEARCH;
              end else begin
                proto_ff <= P_WAIT;
              end
            end
          end
          P_READROM: begin
            bcnt_ff <= bcnt_ff + 6'h01;
            if (bcnt_ff == 6'h3F) begin
              proto_ff <= P_FUNC;
            end
          end
          P_MATCH: begin
            miss_ff <= miss_ff | amiss;
            bcnt_ff <= bcnt_ff + 6'h01;
            if (bcnt_ff == 6'h3F) begin
              proto_ff <= (miss_ff | amiss) ? P_WAIT : P_FUNC;
            end
          end
          P_SEARCH: begin
            if (sub_ff != 2'h2) begin
              sub_ff <= sub_ff + 2'h1;
            end else if (amiss) begin
              proto_ff <= P_WAIT;
            end else begin
              sub_ff  <= 2'h0;
              bcnt_ff <= bcnt_ff + 6'h01;
              if (bcnt_ff == 6'h3F) begin
                proto_ff <= P_FUNC;
              end
            end
          end
          P_FUNC: begin
            sh_ff   <= byte_in;
            bcnt_ff <= last8 ? 6'h00 : bcnt_ff + 6'h01;
            if (last8) begin
              fcmd_ff <= byte_in;
              case (byte_in)
                `SWL_OP_READ, `SWL_OP_WRITE, `SWL_OP_COPY,
                `SWL_OP_RECALL, `SWL_OP_LOCK: proto_ff <= P_ADDR;
                default: proto_ff <= P_WAIT;
              endcase
            end
          end
          P_ADDR: begin
            sh_ff   <= byte_in;
            bcnt_ff <= last8 ? 6'h00 : bcnt_ff + 6'h01;
            if (last8) begin
              addr_ff <= byte_in;
              past_ff <= 1'b0;
              if (fcmd_ff == `SWL_OP_READ) begin
                proto_ff  <= P_RDATA;
                rd_req_ff <= 1'b1;
              end else if (fcmd_ff == `SWL_OP_WRITE) begin
                proto_ff <= P_WDATA;
              end else begin
                proto_ff <= P_WAIT;
              end
            end
          end
          P_RDATA: begin
            sh_ff   <= {1'b1, sh_ff[7:1]};
            bcnt_ff <= last8 ? 6'h00 : bcnt_ff + 6'h01;
            if (last8 && !past_ff) begin
              if (addr_ff == `SWL_ADDR_LAST) begin
                past_ff <= 1'b1;
              end else begin
                addr_ff   <= addr_ff + 8'h01;
                rd_req_ff <= 1'b1;
              end
            end
          end
          P_WDATA: begin
            sh_ff   <= byte_in;
            bcnt_ff <= last8 ? 6'h00 : bcnt_ff + 6'h01;
            if (last8 && !past_ff) begin
              if (addr_ff == `SWL_ADDR_LAST) begin
                past_ff <= 1'b1;
              end else begin
                addr_ff <= addr_ff + 8'h01;
              end
            end
          end
          default: begin
            bcnt_ff <= '0;
          end
        endcase
      end
    end
  end

  assign mem_addr   = addr_ff;
  assign mem_rd_req = rd_req_ff;

  //------------------------------------------------------------
  // line driver
  //------------------------------------------------------------
  logic tx_dir;
  logic tx_bit;
  logic dq_oe_ff;

  always_comb begin
    tx_dir = 1'b0;
    tx_bit = 1'b1;
    case (proto_ff)
      P_READROM: begin
        tx_dir = 1'b1;
        tx_bit = net_address[bcnt_ff];
      end
      P_SEARCH: begin
        tx_dir = sub_ff != 2'h2;
        tx_bit = net_address[bcnt_ff] ^ sub_ff[0];
      end
      P_RDATA: begin
        tx_dir = 1'b1;
        tx_bit = past_ff | sh_ff[0];
      end
      default: begin
        tx_dir = 1'b0;
      end
    endcase
  end

  // read drive ends with the slot's sample point, long before 60us
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_oe_ff <= 1'b0;
    end else begin
      dq_oe_ff <= (link_ff == L_PLOW)
                | (slot_ff & ~bit_done & tx_dir & ~tx_bit & ~rst_hit);
    end
  end

  assign dq_oe  = dq_oe_ff;
  assign dq_out = 1'b0;

  //------------------------------------------------------------
  // nonvolatile commands, copy timer, lock enable
  //------------------------------------------------------------
  logic          addr_done;
  logic          nv_hit;
  logic          copy_go;
  logic          lock_go;
  logic [CW-1:0] copy_cnt_ff;
  logic          busy_ff;
  logic          lock_en_ff;
  logic          copy_ff;
  logic          recall_ff;
  logic          lockr_ff;
  logic          blk_ff;

  assign addr_done = bit_done && proto_ff == P_ADDR && last8 && !rst_hit;
  assign nv_hit    = byte_in[7:5] == `SWL_NV_TOP;
  assign copy_go   = addr_done && fcmd_ff == `SWL_OP_COPY && nv_hit
                   && !block_locked[byte_in[4]] && !busy_ff;
  assign lock_go   = addr_done && fcmd_ff == `SWL_OP_LOCK && nv_hit && lock_en_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      copy_cnt_ff <= '0;
      busy_ff     <= 1'b0;
    end else if (copy_go) begin
      copy_cnt_ff <= COPY_N - 1'b1;
      busy_ff     <= 1'b1;
    end else if (busy_ff) begin
      if (copy_cnt_ff == '0) begin
        busy_ff <= 1'b0;
      end else begin
        copy_cnt_ff <= copy_cnt_ff - 1'b1;
      end
    end
  end

  // a fresh enable in the same cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_en_ff <= 1'b0;
    end else if (lock_enable_set) begin
      lock_en_ff <= 1'b1;
    end else if (lock_go) begin
      lock_en_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      copy_ff   <= 1'b0;
      recall_ff <= 1'b0;
      lockr_ff  <= 1'b0;
      blk_ff    <= 1'b0;
    end else begin
      copy_ff   <= copy_go;
      recall_ff <= addr_done && fcmd_ff == `SWL_OP_RECALL && nv_hit;
      lockr_ff  <= lock_go;
      if (addr_done) begin
        blk_ff <= byte_in[4];
      end
    end
  end

  assign eeprom_copy_busy = busy_ff;
  assign lock_enable      = lock_en_ff;
  assign nv_copy_req      = copy_ff;
  assign nv_recall_req    = recall_ff;
  assign nv_lock_req      = lockr_ff;
  assign nv_block         = blk_ff;

  //------------------------------------------------------------
  // write stream into the fifo
  //------------------------------------------------------------
  logic        wr_evt;
  logic        wr_ok;
  logic        wr_take;
  logic        pend_ff;
  logic [15:0] pend_word_ff;
  logic        fifo_in_ready;
  logic [15:0] fifo_out;

  assign wr_evt  = bit_done && proto_ff == P_WDATA && last8 && !rst_hit;
  assign wr_ok   = !past_ff && mem_addr_writable
                 && (addr_ff[7:5] != `SWL_NV_TOP
                     || (!block_locked[addr_ff[4]] && !busy_ff));
  assign wr_take = wr_evt && wr_ok && (!pend_ff || fifo_in_ready);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff      <= 1'b0;
      pend_word_ff <= '0;
    end else if (wr_take) begin
      pend_ff      <= 1'b1;
      pend_word_ff <= {addr_ff, byte_in};
    end else if (fifo_in_ready) begin
      pend_ff <= 1'b0;
    end
  end

  swl_fifo #(
    .W (16),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (pend_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_word_ff),
    .out_valid (mem_wr_valid),
    .out_ready (mem_wr_ready),
    .out_data  (fifo_out)
  );

  assign mem_wr_addr = fifo_out[15:8];
  assign mem_wr_data = fifo_out[7:0];

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_pres_start: assert property (
    link_ff == L_PWAIT && tmr_ff == PW_N - 1'b1 |=> ##1 dq_oe)
    else $error("presence pulse did not start after wait");
  chk_oe_release: assert property (
    dq_oe && $past(link_ff) != L_PLOW |-> $past(slot_ff) && $past(tx_dir))
    else $error("line driven outside a read slot");
  chk_copy_busy: assert property (
    copy_go |=> eeprom_copy_busy [*8])
    else $error("copy busy not held");
  chk_copy_gate: assert property (
    nv_copy_req |-> !block_locked[nv_block])
    else $error("copy issued to locked block");
  chk_lock_gate: assert property (
    lock_go |-> lock_enable ##1 nv_lock_req)
    else $error("lock without enable");
  chk_lock_clear: assert property (
    nv_lock_req && !$past(lock_enable_set) |-> !lock_enable)
    else $error("lock enable not cleared");
  chk_reset_abort: assert property (
    rst_hit |=> proto_ff == P_WAIT && !dq_oe)
    else $error("reset did not abort transaction");
  chk_nv_write: assert property (
    wr_take && addr_ff[7:5] == `SWL_NV_TOP |-> !busy_ff && !block_locked[addr_ff[4]])
    else $error("nonvolatile write accepted while protected");
  chk_past_end: assert property (
    proto_ff == P_RDATA && past_ff |-> !(slot_ff && dq_oe))
    else $error("data driven past last address");
  chk_sample_time: assert property (
    $rose(slot_ff) |-> !bit_done [*8])
    else $error("bit sampled too early");

  cov_search: cover property (proto_ff == P_SEARCH ##1 proto_ff == P_FUNC);
  cov_copy: cover property (nv_copy_req);
  cov_write: cover property (wr_take);
  cov_read_wrap: cover property (proto_ff == P_RDATA && past_ff);
endmodule : swl_slave
`default_nettype wire

// ==== verification/swl_master.sv ====
// bus master model for the single-wire slave
`timescale 1ns/1ns
`default_nettype none
module swl_master (
  // clock
  input  wire logic clk,
  // line
  input  wire logic dev_oe,
  output logic      dq
);
  logic low_ff = 1'b0;
  // wired-and of both pull-downs over the pullup
  assign dq = !(low_ff || dev_oe);
  task automatic line_reset(output logic pres);
    pres = 1'b0;
    low_ff <= 1'b1;
    repeat (140) @(posedge clk);
    low_ff <= 1'b0;
    repeat (150) begin
      @(posedge clk);
      if (!dq) pres = 1'b1;
    end
  endtask : line_reset
  task automatic wr_bit(input logic b);
    low_ff <= 1'b1;
    repeat (b ? 2 : 60) @(posedge clk);
    low_ff <= 1'b0;
    repeat (b ? 60 : 2) @(posedge clk);
  endtask : wr_bit
  task automatic rd_bit(output logic b);
    low_ff <= 1'b1;
    repeat (2) @(posedge clk);
    low_ff <= 1'b0;
    repeat (13) @(posedge clk);
    b = dq;
    repeat (47) @(posedge clk);
  endtask : rd_bit
  task automatic wr_byte(input logic [7:0] v, input int n = 8);
    for (int i = 0; i < n; i++) wr_bit(v[i]);
  endtask : wr_byte
  task automatic rd_byte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) rd_bit(v[i]);
  endtask : rd_byte
endmodule : swl_master
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the single-wire slave
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       sel = 1'b0;
  logic       les = 1'b0;
  logic       dq, oe, lk_en, busy, wv, cp, rc, lk, blk, p;
  logic [7:0] ma, wa, wd, v;
  logic       dqo, rq, b0, b1;
  logic [1:0] ls;
  logic [1:0] bl = 2'b00;
  logic       wok = 1'b1;
  logic       rdy = 1'b1;
  logic [63:0] na = 64'h0123456789ABCDEF;
  int         rn_ff = 0;
  logic [7:0] wa_ff = 8'h00;
  logic [7:0] wd_ff = 8'h00;
  logic       cp_ff = 1'b0;
  logic       rc_ff = 1'b0;
  logic       lk_ff = 1'b0;
  logic       lkb_ff = 1'b0;
  int         wn_ff = 0;
  int         bc_ff = 0;
  int         err_count = 0;
  int         samples_checked = 0;
  initial forever #10 clk = ~clk;
  swl_master u_mst (.clk(clk), .dev_oe(oe), .dq(dq));
  swl_slave #(.RST_CYC(120), .PWAIT_CYC(30), .PLOW_CYC(40),
              .SMP_CYC(30), .COPY_CYC(50)) u_dut (
    .clk(clk), .rst_n(rst_n), .dq_in(dq), .dq_out(dqo), .dq_oe(oe),
    .net_address(na), .net_address_opcode_select(sel),
    .lock_enable_set(les), .lock_enable(lk_en), .block_locked(bl),
    .eeprom_copy_busy(busy), .link_state(ls), .mem_addr(ma), .mem_rd_req(rq),
    .mem_rd_data(~ma), .mem_addr_writable(wok), .mem_wr_valid(wv),
    .mem_wr_ready(rdy), .mem_wr_addr(wa), .mem_wr_data(wd),
    .nv_copy_req(cp), .nv_recall_req(rc), .nv_lock_req(lk), .nv_block(blk));
  // memory side monitor
  always @(posedge clk) begin
    if (rq) rn_ff <= rn_ff + 1;
    if (wv && rdy) begin
      wn_ff <= wn_ff + 1;
      wa_ff <= wa;
      wd_ff <= wd;
    end
    if (busy) bc_ff <= bc_ff + 1;
    if (cp) cp_ff <= 1'b1;
    if (rc) rc_ff <= 1'b1;
    if (lk) begin
      lk_ff <= 1'b1;
      lkb_ff <= blk;
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic start(input logic [7:0] op);
    u_mst.line_reset(p);
    chk({7'h00, p}, 8'h01);
    chk({6'h00, ls}, {6'h00, swl_pkg::L_IDLE});
    chk({7'h00, dqo}, 8'h00);
    u_mst.wr_byte(op);
  endtask : start
  task automatic cmd(input logic [7:0] op, input logic [7:0] a);
    start(8'hCC);
    u_mst.wr_byte(op);
    u_mst.wr_byte(a);
  endtask : cmd
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    start(8'h33);
    u_mst.rd_byte(v);
    chk(v, 8'hEF);
    sel <= 1'b1;
    start(8'h39);
    u_mst.rd_byte(v);
    chk(v, 8'hEF);
    start(8'h33);
    u_mst.rd_byte(v);
    chk(v, 8'hFF);
    rdy <= 1'b0;
    cmd(8'h6C, 8'hFE);
    u_mst.wr_byte(8'h11);
    u_mst.wr_byte(8'h5A, 3);
    chk(wn_ff[7:0], 8'h00);
    rdy <= 1'b1;
    u_mst.line_reset(p);
    chk(wn_ff[7:0], 8'h01);
    chk(wd_ff, 8'h11);
    cmd(8'h6C, 8'hFF);
    u_mst.wr_byte(8'h22);
    u_mst.wr_byte(8'h33);
    u_mst.line_reset(p);
    chk(wn_ff[7:0], 8'h02);
    chk(wa_ff, 8'hFF);
    chk(wd_ff, 8'h22);
    bl <= 2'b10;
    cmd(8'h48, 8'h30);
    cmd(8'h6C, 8'h30);
    u_mst.wr_byte(8'h44);
    u_mst.line_reset(p);
    chk({7'h00, cp_ff}, 8'h00);
    chk(wn_ff[7:0], 8'h02);
    bl <= 2'b00;
    wok <= 1'b0;
    cmd(8'h6C, 8'h80);
    u_mst.wr_byte(8'h44);
    u_mst.line_reset(p);
    wok <= 1'b1;
    chk(wn_ff[7:0], 8'h02);
    cmd(8'h69, 8'hFE);
    u_mst.rd_byte(v);
    chk(v, 8'h01);
    u_mst.rd_byte(v);
    chk(v, 8'h00);
    u_mst.rd_byte(v);
    chk(v, 8'hFF);
    chk(rn_ff[7:0], 8'h02);
    cmd(8'h48, 8'h20);
    u_mst.line_reset(p);
    chk({7'h00, cp_ff}, 8'h01);
    chk(bc_ff[7:0], 8'h32);
    cmd(8'hB8, 8'h20);
    chk({7'h00, rc_ff}, 8'h01);
    cmd(8'h6A, 8'h30);
    chk({7'h00, lk_ff}, 8'h00);
    les <= 1'b1;
    @(posedge clk);
    les <= 1'b0;
    @(posedge clk);
    chk({7'h00, lk_en}, 8'h01);
    cmd(8'h6A, 8'h30);
    u_mst.line_reset(p);
    chk({6'h00, lk_ff, lkb_ff}, 8'h03);
    chk({7'h00, lk_en}, 8'h00);
    start(8'h55);
    for (int i = 0; i < 8; i++) begin
      u_mst.wr_byte(na[8*i+:8]);
    end
    u_mst.wr_byte(8'h69);
    u_mst.wr_byte(8'hFE);
    u_mst.rd_byte(v);
    chk(v, 8'h01);
    start(8'h55);
    for (int i = 0; i < 8; i++) begin
      u_mst.wr_byte(~na[8*i+:8]);
    end
    u_mst.wr_byte(8'h69);
    u_mst.wr_byte(8'hFE);
    u_mst.rd_byte(v);
    chk(v, 8'hFF);
    start(8'hF0);
    for (int i = 0; i < 64; i++) begin
      u_mst.rd_bit(b0);
      u_mst.rd_bit(b1);
      chk({6'h00, b0, b1}, {6'h00, na[i], ~na[i]});
      u_mst.wr_bit(na[i]);
    end
    u_mst.wr_byte(8'h69);
    u_mst.wr_byte(8'hFE);
    u_mst.rd_byte(v);
    chk(v, 8'h01);
    start(8'hF0);
    u_mst.rd_bit(b0);
    u_mst.rd_bit(b1);
    u_mst.wr_bit(~na[0]);
    u_mst.rd_bit(b0);
    u_mst.rd_bit(b1);
    chk({6'h00, b0, b1}, 8'h03);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
